/* dv/swc_cpu_model.sv */
// cpu core and peripheral event sources facing the sleep and wake controller
`timescale 1ns/10ps
module swc_cpu_model (
  // clock
  input  wire logic              sys_clk,
  // cpu side
  input  wire logic              cpuClockEnable,
  output      logic              sleepExec,
  output      logic [10:0]       pcNow,
  // peripheral events
  output      swc_pkg::swc_evt_t evt
);
  // quiet at time zero
  initial begin
    sleepExec = 1'h0;
    pcNow = 11'h000;
    evt = '0;
  end
  // one sleep instruction, issued only while the core clock runs
  task automatic sleep_at(input logic [10:0] pc);
    while (cpuClockEnable !== 1'h1) @(posedge sys_clk);
    sleepExec <= 1'h1;
    pcNow <= pc;
    @(posedge sys_clk);
    sleepExec <= 1'h0; // nothing but a no-operation follows sleep
    pcNow <= ~pc; // address is inverted once the pulse is gone
  endtask
  // one-cycle event pulses into the request registers
  task automatic fire(input logic [7:0] one, input logic [7:0] two, input logic [7:0] three);
    evt.reqOne <= one;
    evt.reqTwo <= two;
    evt.reqThree <= three;
    @(posedge sys_clk);
    evt <= '0;
  endtask
endmodule

/* dv/tb.sv */
// self-checking bench for the sleep and wake controller
`timescale 1ns/10ps
module tb;
  logic sys_clk, srst, ce, sleepExec, cpuClockEnable, cpuIrq, wakePulse, resumeVector, wdtTimeout, wdtClear;
  logic extIntPin, extResetPinN, brownOutReq, powerOnReq, resetPinEnable, brownOutEnable, wdtEnable;
  logic wdtSleepEnable, adcDedicatedOsc, wdtRun, lfOscRun, timerOneRun, adcRun, portHold;
  logic regulatorLowPower, deviceReset;
  logic [10:0]           pcNow, fetchAddr;
  swc_pkg::swc_evt_t     evt;
  swc_pkg::swc_t1src_t   timerOneSrc;
  swc_pkg::swc_axi_req_t req;
  swc_pkg::swc_axi_rsp_t rsp;
  int                    mismatches, tests_run, cycles;

  // design and its core-side partner
  swc_top dut (.sys_clk, .srst, .ce, .axiReq(req), .axiRsp(rsp), .sleepExec, .pcNow, .fetchAddr,
    .cpuClockEnable, .cpuIrq, .wakePulse, .resumeVector, .evt, .extIntPin, .extResetPinN, .brownOutReq,
    .powerOnReq, .resetPinEnable, .brownOutEnable, .wdtEnable, .wdtSleepEnable, .timerOneSrc,
    .adcDedicatedOsc, .wdtTimeout, .wdtClear, .wdtRun, .lfOscRun, .timerOneRun, .adcRun, .portHold,
    .regulatorLowPower, .deviceReset);
  swc_cpu_model cpu (.sys_clk, .cpuClockEnable, .sleepExec, .pcNow, .evt);

  // compare and count
  task automatic ck(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // axi4-lite write, address and data offered together; handshakes judged on settled values
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic awGo;
    logic wGo;
    logic bGo;
    req.awaddr <= a;
    req.wdata <= {24'h000000, d};
    req.wstrb <= 4'hF;
    req.awvalid <= 1'h1;
    req.wvalid <= 1'h1;
    do begin
      @(negedge sys_clk);
      awGo = req.awvalid && (rsp.awready === 1'h1);
      wGo = req.wvalid && (rsp.wready === 1'h1);
      bGo = (rsp.bvalid === 1'h1);
      @(posedge sys_clk);
      if (awGo) req.awvalid <= 1'h0;
      if (wGo) req.wvalid <= 1'h0;
    end while (!bGo);
  endtask
  // axi4-lite read with data and response check; data taken while it stands
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [1:0] er);
    logic        arGo;
    logic        rGo;
    logic [31:0] gotData;
    logic [1:0]  gotResp;
    req.araddr <= a;
    req.arvalid <= 1'h1;
    do begin
      @(negedge sys_clk);
      arGo = req.arvalid && (rsp.arready === 1'h1);
      rGo = (rsp.rvalid === 1'h1);
      gotData = rsp.rdata;
      gotResp = rsp.rresp;
      @(posedge sys_clk);
      if (arGo) req.arvalid <= 1'h0;
    end while (!rGo);
    ck(gotData, {24'h000000, exp});
    ck({30'h0, gotResp}, {30'h0, er});
  endtask
  // wait for the wake pulse and check what travels with it
  task automatic wake_check(input logic vec);
    do @(negedge sys_clk); while (wakePulse !== 1'h1);
    ck({31'h0, resumeVector}, {31'h0, vec});
    ck({31'h0, wdtClear}, 32'h1);
    ck({31'h0, cpuIrq}, {31'h0, vec});
    @(posedge sys_clk);
  endtask
  // verdict and end of run
  task automatic complete_run();
    if (mismatches == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // clock
  initial begin
    sys_clk = 1'h0;
    forever #2 sys_clk = ~sys_clk;
  end
  // hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      complete_run();
    end
  end
  // main sequence
  initial begin
    {ce, srst, extResetPinN, wdtEnable, wdtSleepEnable} = 5'h1F;
    {extIntPin, brownOutReq, powerOnReq, resetPinEnable, brownOutEnable, adcDedicatedOsc, wdtTimeout} = 7'h00;
    timerOneSrc = swc_pkg::SWC_T1_LFOSC;
    req = '0;
    req.bready = 1'h1;
    req.rready = 1'h1;
    repeat (4) @(posedge sys_clk);
    srst <= 1'h0;
    @(posedge sys_clk);
    rd(swc_pkg::SWC_OFS_STATUS, 8'h18, 2'h0);
    rd(swc_pkg::SWC_OFS_REG_CTL, 8'h01, 2'h0);
    rd(swc_pkg::SWC_OFS_REQ_TWO, 8'h00, 2'h0);
    rd(8'h28, 8'h00, swc_pkg::SWC_RESP_SLVERR);
    cpu.fire(8'hFF, 8'hFF, 8'hFF);
    rd(swc_pkg::SWC_OFS_REQ_ONE, 8'hCB, 2'h0);
    rd(swc_pkg::SWC_OFS_REQ_TWO, 8'h6C, 2'h0);
    rd(swc_pkg::SWC_OFS_REQ_THREE, 8'h03, 2'h0);
    wr(swc_pkg::SWC_OFS_REQ_TWO, 8'h00);
    wr(swc_pkg::SWC_OFS_INT_CTL, 8'h40);
    wr(swc_pkg::SWC_OFS_EN_TWO, 8'h20);
    // enabled flag already pending: sleep does nothing
    cpu.fire(8'h00, 8'h20, 8'h00);
    cpu.sleep_at(11'h123);
    @(negedge sys_clk);
    ck({31'h0, cpuClockEnable}, 32'h1);
    ck({21'h0, fetchAddr}, 32'h124);
    @(posedge sys_clk);
    rd(swc_pkg::SWC_OFS_STATUS, 8'h18, 2'h0);
    wr(swc_pkg::SWC_OFS_REQ_TWO, 8'h00);
    wr(swc_pkg::SWC_OFS_REG_CTL, 8'h02);
    // real sleep, woken by an enabled peripheral flag
    cpu.sleep_at(11'h200);
    @(negedge sys_clk);
    ck({28'h0, cpuClockEnable, regulatorLowPower, portHold, lfOscRun}, 32'h7);
    ck({29'h0, wdtRun, timerOneRun, adcRun}, 32'h6);
    @(posedge sys_clk);
    rd(swc_pkg::SWC_OFS_STATUS, 8'h10, 2'h0);
    rd(swc_pkg::SWC_OFS_REG_CTL, 8'h03, 2'h0);
    cpu.fire(8'h00, 8'h04, 8'h00);
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    ck({31'h0, cpuClockEnable}, 32'h0);
    @(posedge sys_clk);
    cpu.fire(8'h00, 8'h20, 8'h00);
    wake_check(1'h0);
    wr(swc_pkg::SWC_OFS_REQ_TWO, 8'h00);
    // watchdog time-out ends sleep
    cpu.sleep_at(11'h300);
    wdtTimeout <= 1'h1;
    @(posedge sys_clk);
    wdtTimeout <= 1'h0;
    wake_check(1'h0);
    rd(swc_pkg::SWC_OFS_STATUS, 8'h00, 2'h0);
    // global enable set: wake then vector
    wr(swc_pkg::SWC_OFS_INT_CTL, 8'hC0);
    cpu.sleep_at(11'h340);
    cpu.fire(8'h00, 8'h20, 8'h00);
    wake_check(1'h1);
    wr(swc_pkg::SWC_OFS_REQ_TWO, 8'h00);
    // power-on request ends sleep by device reset
    cpu.sleep_at(11'h400);
    powerOnReq <= 1'h1;
    do @(negedge sys_clk); while (deviceReset !== 1'h1);
    @(posedge sys_clk);
    powerOnReq <= 1'h0;
    repeat (4) @(posedge sys_clk);
    rd(swc_pkg::SWC_OFS_STATUS, 8'h18, 2'h0);
    ck({31'h0, cpuClockEnable}, 32'h1);
    complete_run();
  end
endmodule

/* inc/swc_pkg.sv */
// constants, types and register map of the sleep and wake controller
package swc_pkg;
  // register byte offsets
  localparam logic [7:0] SWC_OFS_INT_CTL    = 8'h00;
  localparam logic [7:0] SWC_OFS_EN_ONE     = 8'h04;
  localparam logic [7:0] SWC_OFS_EN_TWO     = 8'h08;
  localparam logic [7:0] SWC_OFS_EN_THREE   = 8'h0C;
  localparam logic [7:0] SWC_OFS_REQ_ONE    = 8'h10;
  localparam logic [7:0] SWC_OFS_REQ_TWO    = 8'h14;
  localparam logic [7:0] SWC_OFS_REQ_THREE  = 8'h18;
  localparam logic [7:0] SWC_OFS_STATUS     = 8'h1C;
  localparam logic [7:0] SWC_OFS_REG_CTL    = 8'h20;
  localparam logic [7:0] SWC_OFS_SLEEP_STAT = 8'h24;
  // interrupt control fields
  localparam int SWC_IC_GLOBAL_EN = 7;
  localparam int SWC_IC_PERIPH_EN = 6;
  localparam int SWC_IC_TMR0_EN   = 5;
  localparam int SWC_IC_TMR0_FLAG = 2;
  localparam int SWC_IC_EXT_FLAG  = 1;
  localparam int SWC_IC_CHG_FLAG  = 0;
  // implemented bits of the enable and flag registers
  localparam logic [7:0] SWC_MASK_ONE    = 8'hCB;
  localparam logic [7:0] SWC_MASK_TWO    = 8'h6C;
  localparam logic [7:0] SWC_MASK_THREE  = 8'h03;
  localparam logic [7:0] SWC_MASK_INT_WR = 8'hFE;
  // status, regulator and sleep-state fields
  localparam int SWC_ST_TIME_OUT    = 4;
  localparam int SWC_ST_POWER_DOWN  = 3;
  localparam int SWC_RC_POWER_MODE  = 1;
  localparam int SWC_RC_RESERVED    = 0;
  localparam int SWC_SS_ASLEEP      = 0;
  // pin synchroniser order and idle value (reset pin idles high)
  localparam int SWC_PIN_EXT_INT    = 0;
  localparam int SWC_PIN_RESET_N    = 1;
  localparam int SWC_PIN_BROWN_OUT  = 2;
  localparam int SWC_PIN_POWER_ON   = 3;
  localparam logic [3:0] SWC_SYNC_IDLE = 4'h2;
  // bus answers
  localparam logic [1:0] SWC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] SWC_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {SWC_AWAKE = 2'b00, SWC_ASLEEP = 2'b01} swc_sleep_t;
  typedef enum logic [1:0] {
    SWC_T1_INSTR = 2'b00, SWC_T1_SYS = 2'b01, SWC_T1_LFOSC = 2'b10, SWC_T1_PIN = 2'b11
  } swc_t1src_t;

  typedef struct packed {
    logic [7:0]  awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [7:0]  araddr;
    logic        arvalid;
    logic        rready;
  } swc_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } swc_axi_rsp_t;

  typedef struct packed {
    logic [7:0] reqOne;
    logic [7:0] reqTwo;
    logic [7:0] reqThree;
    logic       timerZero;
    logic       iocAny;
  } swc_evt_t;

  typedef struct packed {
    logic       awHave;
    logic [7:0] awAddr;
    logic       wHave;
    logic [7:0] wData;
    logic       wLane;
    logic       bValid;
    logic [1:0] bResp;
    logic       rValid;
    logic [7:0] rData;
    logic [1:0] rResp;
  } swc_bus_t;

  typedef struct packed {
    swc_bus_t    bus;
    swc_sleep_t  sleepState;
    logic [7:0]  intCtl;
    logic [7:0]  enOne;
    logic [7:0]  enTwo;
    logic [7:0]  enThree;
    logic [7:0]  reqOne;
    logic [7:0]  reqTwo;
    logic [7:0]  reqThree;
    logic        timeOut;
    logic        powerDown;
    logic        regPowerMode;
    logic [3:0]  syncA;
    logic [3:0]  syncB;
    logic        extPrev;
    logic        wdtClear;
    logic        wake;
    logic        resumeVec;
    logic        devReset;
    logic [10:0] fetchAddr;
  } swc_state_t;

  function automatic swc_state_t swc_reset_state();
    swc_state_t r;
    r           = '0;
    r.timeOut   = 1'b1;
    r.powerDown = 1'b1;
    r.syncA     = SWC_SYNC_IDLE;
    r.syncB     = SWC_SYNC_IDLE;
    return r;
  endfunction
endpackage

/* verilog/swc_top.sv */
// sleep entry, wake-up and interrupt request flags with an axi4-lite register port
`timescale 1ns/10ps
module swc_top (
  // clock, reset, enable
  input  wire logic                 sys_clk,
  input  wire logic                 srst,
  input  wire logic                 ce,
  // register bus
  input  wire swc_pkg::swc_axi_req_t axiReq,
  output      swc_pkg::swc_axi_rsp_t axiRsp,
  // cpu core
  input  wire logic                 sleepExec,
  input  wire logic [10:0]          pcNow,
  output      logic [10:0]          fetchAddr,
  output      logic                 cpuClockEnable,
  output      logic                 cpuIrq,
  output      logic                 wakePulse,
  output      logic                 resumeVector,
  // peripheral events from same-clock logic
  input  wire swc_pkg::swc_evt_t    evt,
  // pins
  input  wire logic                 extIntPin,
  input  wire logic                 extResetPinN,
  input  wire logic                 brownOutReq,
  input  wire logic                 powerOnReq,
  // configuration
  input  wire logic                 resetPinEnable,
  input  wire logic                 brownOutEnable,
  input  wire logic                 wdtEnable,
  input  wire logic                 wdtSleepEnable,
  input  wire swc_pkg::swc_t1src_t  timerOneSrc,
  input  wire logic                 adcDedicatedOsc,
  // watchdog
  input  wire logic                 wdtTimeout,
  output      logic                 wdtClear,
  output      logic                 wdtRun,
  // clocks, ports, regulator, reset
  output      logic                 lfOscRun,
  output      logic                 timerOneRun,
  output      logic                 adcRun,
  output      logic                 portHold,
  output      logic                 regulatorLowPower,
  output      logic                 deviceReset
);
  swc_pkg::swc_state_t s;
  swc_pkg::swc_state_t n;
  logic                awake;
  logic                asleep;
  logic                rstNow;
  logic [2:0]          coreWake;
  logic                periphWake;
  logic                wakeReq;

  // state decode
  assign awake  = (s.sleepState == swc_pkg::SWC_AWAKE);
  assign asleep = (s.sleepState == swc_pkg::SWC_ASLEEP);

  // reset sources act alike awake or asleep
  assign rstNow = (resetPinEnable & ~s.syncB[swc_pkg::SWC_PIN_RESET_N])
                | (brownOutEnable & s.syncB[swc_pkg::SWC_PIN_BROWN_OUT])
                | s.syncB[swc_pkg::SWC_PIN_POWER_ON];

  // wake request: flag and enable pairs, peripherals behind their gate
  assign coreWake   = s.intCtl[swc_pkg::SWC_IC_TMR0_EN -: 3]
                    & s.intCtl[swc_pkg::SWC_IC_TMR0_FLAG -: 3];
  assign periphWake = s.intCtl[swc_pkg::SWC_IC_PERIPH_EN]
                    & (|((s.enOne & s.reqOne) | (s.enTwo & s.reqTwo) | (s.enThree & s.reqThree)));
  assign wakeReq    = (|coreWake) | periphWake;

  // next-state logic
  always_comb begin
    logic       awTake;
    logic       wTake;
    logic       arTake;
    logic       wrGo;
    logic [7:0] wrAddr;
    logic [7:0] wrData;
    logic       wrLane;
    logic [7:0] rd;
    logic       hit;
    logic       extEdge;
    logic [7:0] setCtl;
    swc_pkg::swc_bus_t keepBus;
    logic [3:0] keepA;
    logic [3:0] keepB;
    awTake  = axiReq.awvalid & axiRsp.awready;
    wTake   = axiReq.wvalid & axiRsp.wready;
    arTake  = axiReq.arvalid & axiRsp.arready;
    wrGo    = (s.bus.awHave | awTake) & (s.bus.wHave | wTake);
    wrAddr  = s.bus.awHave ? s.bus.awAddr : axiReq.awaddr;
    wrData  = s.bus.wHave ? s.bus.wData : axiReq.wdata[7:0];
    wrLane  = s.bus.wHave ? s.bus.wLane : axiReq.wstrb[0];
    rd      = 8'h00;
    hit     = 1'b1;
    extEdge = s.syncB[swc_pkg::SWC_PIN_EXT_INT] & ~s.extPrev;
    setCtl  = 8'h00;
    keepBus = s.bus;
    keepA   = s.syncA;
    keepB   = s.syncB;
    n       = s;

    // pin synchronisers and edge memory
    n.syncA    = {powerOnReq, brownOutReq, extResetPinN, extIntPin};
    n.syncB    = s.syncA;
    n.extPrev  = s.syncB[swc_pkg::SWC_PIN_EXT_INT];
    n.wdtClear = 1'b0;
    n.wake     = 1'b0;
    n.resumeVec = 1'b0;
    n.devReset = 1'b0;

    // write channel capture and answer
    if (awTake) begin
      n.bus.awHave = 1'b1;
      n.bus.awAddr = axiReq.awaddr;
    end
    if (wTake) begin
      n.bus.wHave = 1'b1;
      n.bus.wData = axiReq.wdata[7:0];
      n.bus.wLane = axiReq.wstrb[0];
    end
    if (s.bus.bValid && axiReq.bready) begin
      n.bus.bValid = 1'b0;
    end
    if (wrGo) begin
      n.bus.awHave = 1'b0;
      n.bus.wHave  = 1'b0;
      n.bus.bValid = 1'b1;
      case ({wrAddr[7:2], 2'b00})
        swc_pkg::SWC_OFS_INT_CTL: begin
          if (wrLane) begin
            n.intCtl = (wrData & swc_pkg::SWC_MASK_INT_WR) | (s.intCtl & ~swc_pkg::SWC_MASK_INT_WR);
          end
        end
        swc_pkg::SWC_OFS_EN_ONE: begin
          if (wrLane) begin
            n.enOne = wrData & swc_pkg::SWC_MASK_ONE;
          end
        end
        swc_pkg::SWC_OFS_EN_TWO: begin
          if (wrLane) begin
            n.enTwo = wrData & swc_pkg::SWC_MASK_TWO;
          end
        end
        swc_pkg::SWC_OFS_EN_THREE: begin
          if (wrLane) begin
            n.enThree = wrData & swc_pkg::SWC_MASK_THREE;
          end
        end
        swc_pkg::SWC_OFS_REQ_ONE: begin
          if (wrLane) begin
            n.reqOne = wrData & swc_pkg::SWC_MASK_ONE;
          end
        end
        swc_pkg::SWC_OFS_REQ_TWO: begin
          if (wrLane) begin
            n.reqTwo = wrData & swc_pkg::SWC_MASK_TWO;
          end
        end
        swc_pkg::SWC_OFS_REQ_THREE: begin
          if (wrLane) begin
            n.reqThree = wrData & swc_pkg::SWC_MASK_THREE;
          end
        end
        swc_pkg::SWC_OFS_REG_CTL: begin
          if (wrLane) begin
            n.regPowerMode = wrData[swc_pkg::SWC_RC_POWER_MODE];
          end
        end
        swc_pkg::SWC_OFS_STATUS, swc_pkg::SWC_OFS_SLEEP_STAT: begin
          n.bus.bValid = 1'b1;                                               // read-only, write ignored
        end
        default: begin
          hit = 1'b0;
        end
      endcase
      n.bus.bResp = hit ? swc_pkg::SWC_RESP_OKAY : swc_pkg::SWC_RESP_SLVERR;
    end

    // flag events win over a clearing write in the same cycle
    setCtl[swc_pkg::SWC_IC_TMR0_FLAG] = evt.timerZero;
    setCtl[swc_pkg::SWC_IC_EXT_FLAG]  = extEdge;
    n.intCtl   = n.intCtl | setCtl;
    n.intCtl[swc_pkg::SWC_IC_CHG_FLAG] = evt.iocAny;                         // live change flag
    n.reqOne   = n.reqOne | (evt.reqOne & swc_pkg::SWC_MASK_ONE);
    n.reqTwo   = n.reqTwo | (evt.reqTwo & swc_pkg::SWC_MASK_TWO);
    n.reqThree = n.reqThree | (evt.reqThree & swc_pkg::SWC_MASK_THREE);

    // read channel
    if (s.bus.rValid && axiReq.rready) begin
      n.bus.rValid = 1'b0;
    end
    if (arTake) begin
      hit = 1'b1;
      case ({axiReq.araddr[7:2], 2'b00})
        swc_pkg::SWC_OFS_INT_CTL:   rd = s.intCtl;
        swc_pkg::SWC_OFS_EN_ONE:    rd = s.enOne;
        swc_pkg::SWC_OFS_EN_TWO:    rd = s.enTwo;
        swc_pkg::SWC_OFS_EN_THREE:  rd = s.enThree;
        swc_pkg::SWC_OFS_REQ_ONE:   rd = s.reqOne;
        swc_pkg::SWC_OFS_REQ_TWO:   rd = s.reqTwo;
        swc_pkg::SWC_OFS_REQ_THREE: rd = s.reqThree;
        swc_pkg::SWC_OFS_STATUS: begin
          rd[swc_pkg::SWC_ST_TIME_OUT]   = s.timeOut;
          rd[swc_pkg::SWC_ST_POWER_DOWN] = s.powerDown;
        end
        swc_pkg::SWC_OFS_REG_CTL: begin
          rd[swc_pkg::SWC_RC_POWER_MODE] = s.regPowerMode;
          rd[swc_pkg::SWC_RC_RESERVED]   = 1'b1;
        end
        swc_pkg::SWC_OFS_SLEEP_STAT: begin
          rd[swc_pkg::SWC_SS_ASLEEP] = asleep;
        end
        default: begin
          hit = 1'b0;
        end
      endcase
      n.bus.rValid = 1'b1;
      n.bus.rData  = rd;
      n.bus.rResp  = hit ? swc_pkg::SWC_RESP_OKAY : swc_pkg::SWC_RESP_SLVERR;
    end

    // sleep sequencer
    case (s.sleepState)
      swc_pkg::SWC_AWAKE: begin
        if (sleepExec) begin
          n.fetchAddr = 11'(pcNow + 11'h001);
          if (!wakeReq) begin
            n.sleepState = swc_pkg::SWC_ASLEEP;
            n.wdtClear   = 1'b1;
            n.powerDown  = 1'b0;
            n.timeOut    = 1'b1;
          end
        end
      end
      swc_pkg::SWC_ASLEEP: begin
        if (wakeReq || wdtTimeout) begin
          n.sleepState = swc_pkg::SWC_AWAKE;
          n.wdtClear   = 1'b1;
          n.wake       = 1'b1;
          n.resumeVec  = wakeReq & s.intCtl[swc_pkg::SWC_IC_GLOBAL_EN];
          if (wdtTimeout && !wakeReq) begin
            n.timeOut = 1'b0;
          end
        end
      end
      default: begin
        n.sleepState = swc_pkg::SWC_AWAKE;
      end
    endcase

    // a reset source clears the device but leaves the bus and pins intact
    if (rstNow) begin
      keepBus    = n.bus;
      keepA      = n.syncA;
      keepB      = n.syncB;
      n          = swc_pkg::swc_reset_state();
      n.bus      = keepBus;
      n.syncA    = keepA;
      n.syncB    = keepB;
      n.devReset = 1'b1;
    end

    // low enable freezes everything
    if (!ce) begin
      n = s;
    end
  end

  // state register
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s <= swc_pkg::swc_reset_state();
    end else begin
      s <= n;
    end
  end

  // bus answers: readies from state, data from flops
  assign axiRsp.awready = ce & ~s.bus.awHave & ~s.bus.bValid;
  assign axiRsp.wready  = ce & ~s.bus.wHave & ~s.bus.bValid;
  assign axiRsp.bvalid  = s.bus.bValid;
  assign axiRsp.bresp   = s.bus.bResp;
  assign axiRsp.arready = ce & ~s.bus.rValid;
  assign axiRsp.rvalid  = s.bus.rValid;
  assign axiRsp.rdata   = {24'h000000, s.bus.rData};
  assign axiRsp.rresp   = s.bus.rResp;

  // cpu side
  assign fetchAddr      = s.fetchAddr;
  assign cpuClockEnable = awake;
  assign cpuIrq         = awake & wakeReq & s.intCtl[swc_pkg::SWC_IC_GLOBAL_EN];
  assign wakePulse      = s.wake;
  assign resumeVector   = s.resumeVec;
  assign deviceReset    = s.devReset;

  // watchdog control
  assign wdtClear = s.wdtClear;
  assign wdtRun   = wdtEnable & (awake | wdtSleepEnable);

  // what stays alive in sleep
  assign lfOscRun    = 1'b1;
  assign timerOneRun = awake | (timerOneSrc == swc_pkg::SWC_T1_LFOSC)
                     | (timerOneSrc == swc_pkg::SWC_T1_PIN);
  assign adcRun      = awake | adcDedicatedOsc;
  assign portHold    = asleep;
  assign regulatorLowPower = asleep & s.regPowerMode;

  // checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);

  sequence sleepEntry;
    ce && awake && sleepExec && !wakeReq && !rstNow;
  endsequence
  sequence sleepNop;
    ce && awake && sleepExec && wakeReq && !rstNow;
  endsequence
  sequence wakeHit;
    ce && asleep && wakeReq && !rstNow;
  endsequence

  a_flag_sets_free: assert property (
    ce && !rstNow && evt.reqThree[0] |=> s.reqThree[0])
    else $error("logic cell one flag missed its event");
  a_unused_bits_zero: assert property (
    ((s.reqTwo & ~swc_pkg::SWC_MASK_TWO) == 8'h00) && ((s.reqThree & ~swc_pkg::SWC_MASK_THREE) == 8'h00))
    else $error("unimplemented flag bit set");
  a_sleep_cause: assert property (
    $rose(asleep) |-> $past(sleepExec) && $past(ce))
    else $error("sleep entered without the sleep instruction");
  a_entry_effects: assert property (
    sleepEntry |=> wdtClear && !s.powerDown && s.timeOut && !cpuClockEnable && portHold)
    else $error("sleep entry effects wrong");
  a_nop_sleep: assert property (
    sleepNop |=> awake && !wdtClear && $stable(s.timeOut) && $stable(s.powerDown))
    else $error("pending sleep did not act as no-operation");
  a_wake_at_once: assert property (
    sleepEntry ##1 wakeHit |=> wakePulse && wdtClear && cpuClockEnable && !s.powerDown)
    else $error("late flag did not wake right after sleep");
  a_resume_vector: assert property (
    wakeHit |=> wakePulse && (resumeVector == $past(s.intCtl[swc_pkg::SWC_IC_GLOBAL_EN])))
    else $error("resume vector does not follow global enable");
  a_wdt_wake: assert property (
    ce && asleep && wdtTimeout && !wakeReq && !rstNow |=> wdtClear && !s.timeOut && awake)
    else $error("watchdog wake effects wrong");
  a_sleep_clocks: assert property (
    asleep && (timerOneSrc == swc_pkg::SWC_T1_PIN) |-> timerOneRun && lfOscRun)
    else $error("timer one stopped in sleep");

  a_adc_sleep_run: assert property (
    asleep && adcDedicatedOsc |-> adcRun)
    else $error("converter stopped in sleep on its own oscillator");
  a_regulator_mode: assert property (
    sleepEntry |=> (regulatorLowPower == s.regPowerMode) && !$past(regulatorLowPower))
    else $error("regulator mode wrong around sleep");
  a_periph_gate: assert property (
    !s.intCtl[swc_pkg::SWC_IC_PERIPH_EN] && (coreWake == 3'h0) |-> !wakeReq)
    else $error("peripheral woke without its gate");
  a_reset_wake: assert property (
    ce && asleep && rstNow |=> awake && deviceReset && s.powerDown)
    else $error("reset source did not end sleep");
endmodule
